/* verilog/motor_pwm_timebase_brake.v */
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "motor_pwm_regs.vh"
module motor_pwm_timebase_brake
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Bus slave
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire hready_in,
	input wire [31:0] hwdata_in,
	output wire [31:0] hrdata_out,
	output wire hreadyout_out,
	output wire hresp_out,
	// Pins and system
	input wire brake_input_zero_in,
	input wire brake_input_one_in,
	input wire in_circuit_programming_in,
	input wire [7:0] port_mode_regs_n_in,
	input wire [1:0] hz_config_in,
	input wire ext_irq_enable_one_in,
	// Outputs
	output wire [7:0] pwm_out,
	output wire [7:0] pwm_oe_n_out,
	output wire irq_request_out
);
// ****************
// Storage
// ****************
reg [11:0] buf_reg [0:4];
reg [11:0] act_reg [0:4];
reg [7:0] c1_reg, c3_reg, c4_reg, blev_reg, pol_reg;
reg [7:0] dten_reg, dtc_reg, psc_reg, psc_cnt_reg;
reg [7:0] c1_next;
reg [11:0] cnt_reg;
reg down_reg, run_d_reg, cfg_done_reg;
reg [3:0] gen_reg;
reg hold0_reg, hold1_reg, f0_d_reg, f1_d_reg;
reg [4:0] ta_cnt_reg;
reg ta_armed_reg, ta_open_reg;
reg [7:0] a_reg;
reg wr_reg, rd_reg, hready_reg;
reg [31:0] hrdata_reg;
reg [7:0] rd_mux;
reg [7:0] pwm_reg, oe_n_reg;
reg irq_reg;
reg [5:0] raw;
integer i, j, k, n;
wire f0, f1;
wire [2:0] dt_even, dt_odd;
// ****************
// Helpers
// ****************
function gen_f;
	input cur, tk;
	input [11:0] duty, per, nxt;
	begin
		if (duty == `RST_VAL12)
			gen_f = 1'b0;
		else if (duty == `DUTY_ALL_ONES || duty > per)
			gen_f = 1'b1;
		else if (!tk)
			gen_f = cur;
		else
			gen_f = (nxt < duty);
	end
endfunction
// ****************
// Bus slave
// ****************
wire take = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'b010);
wire [7:0] wd = hwdata_in[7:0];
wire wen = wr_reg;
assign hrdata_out = hrdata_reg;
assign hreadyout_out = hready_reg;
assign hresp_out = 1'b0;
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		a_reg <= 8'h00;
		wr_reg <= 1'b0;
		rd_reg <= 1'b0;
		hready_reg <= 1'b1;
		hrdata_reg <= 32'h0000_0000;
	end
	else
	begin
		if (take)
			a_reg <= haddr_in[7:0];
		wr_reg <= take & hwrite_in;
		rd_reg <= take & ~hwrite_in;
		hready_reg <= ~(take & ~hwrite_in);
		if (rd_reg)
			hrdata_reg <= {24'h00_0000, rd_mux};
	end
end
always @*
begin
	rd_mux = 8'h00;
	if (a_reg <= `OFS_BUF_LAST && a_reg[1:0] == 2'b00)
		rd_mux = a_reg[2] ? {4'h0, buf_reg[a_reg[5:3]][11:8]}
			: buf_reg[a_reg[5:3]][7:0];
	else
		case (a_reg)
		`OFS_CTRL_ONE: rd_mux = c1_reg;
		`OFS_CTRL_THREE: rd_mux = c3_reg;
		`OFS_CTRL_FOUR: rd_mux = c4_reg;
		`OFS_BRAKE_LEVEL: rd_mux = blev_reg;
		`OFS_POLARITY: rd_mux = pol_reg;
		`OFS_DT_ENABLE: rd_mux = dten_reg;
		`OFS_DT_COUNT: rd_mux = dtc_reg;
		`OFS_PRESCALE: rd_mux = psc_reg;
		`OFS_CNT_LO: rd_mux = cnt_reg[7:0];
		`OFS_CNT_HI: rd_mux = {down_reg, 3'b000, cnt_reg[11:8]};
		default: rd_mux = 8'h00;
		endcase
end
wire wbuf = wen && a_reg <= `OFS_BUF_LAST && a_reg[1:0] == 2'b00;
// ****************
// Time base
// ****************
wire run = c1_reg[`C1_RUN];
wire center = c3_reg[`C3_CENTER];
wire in_circuit_programming = in_circuit_programming_in;
wire [11:0] per = act_reg[0];
wire per_match = (cnt_reg == per);
wire [11:0] cnt_nxt = !center ? (per_match ? 12'h000 : cnt_reg + 12'h001)
	: !down_reg ? (per_match ? cnt_reg - 12'h001 : cnt_reg + 12'h001)
	: (cnt_reg == 12'h000) ? 12'h001 : cnt_reg - 12'h001;
wire tick = run & ~in_circuit_programming & (psc_cnt_reg == psc_reg);
wire run_rise = run & ~run_d_reg;
wire pstart = tick & (center ? (down_reg & cnt_reg == 12'h000)
	: per_match);
wire ievt = (center & c3_reg[`C3_INT_TYPE]) ? (tick & ~down_reg & per_match)
	: pstart;
wire b0_fall = f0_d_reg & ~f0 & c4_reg[0];
wire b1_fall = f1_d_reg & ~f1 & c4_reg[1];
wire force1 = c4_reg[1] & c4_reg[`C4_AUTO1] & ~f1;
wire forced = hold0_reg | hold1_reg | force1;
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		psc_cnt_reg <= 8'h00;
		cnt_reg <= `RST_VAL12;
		down_reg <= 1'b0;
		run_d_reg <= 1'b0;
		for (i = 0; i < 5; i = i + 1)
		begin
			buf_reg[i] <= `RST_VAL12;
			act_reg[i] <= `RST_VAL12;
		end
	end
	else
	begin
		run_d_reg <= run;
		psc_cnt_reg <= (tick | ~run) ? 8'h00 : psc_cnt_reg + 8'h01;
		if (wbuf && a_reg[2])
			buf_reg[a_reg[5:3]][11:8] <= wd[3:0];
		else if (wbuf)
			buf_reg[a_reg[5:3]][7:0] <= wd;
		if (run_rise)
		begin
			cnt_reg <= `RST_VAL12;
			down_reg <= 1'b0;
			act_reg[0] <= buf_reg[0];
		end
		else if (tick)
		begin
			cnt_reg <= cnt_nxt;
			down_reg <= center & (down_reg ? (cnt_reg != 12'h000)
				: per_match);
		end
		if (pstart && c1_reg[`C1_LOAD] && !run_rise)
			for (i = 0; i < 5; i = i + 1)
				act_reg[i] <= buf_reg[i];
	end
end
// ****************
// Generators and brake
// ****************
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		gen_reg <= 4'h0;
		hold0_reg <= 1'b0;
		hold1_reg <= 1'b0;
		f0_d_reg <= 1'b1;
		f1_d_reg <= 1'b1;
	end
	else
	begin
		for (j = 0; j < 4; j = j + 1)
			gen_reg[j] <= gen_f(gen_reg[j], tick & ~run_rise,
				act_reg[j + 1], per, cnt_nxt);
		f0_d_reg <= f0;
		f1_d_reg <= f1;
		if (b0_fall)
			hold0_reg <= 1'b1;
		else if (pstart)
			hold0_reg <= 1'b0;
		if (force1)
			hold1_reg <= 1'b1;
		else if (pstart)
			hold1_reg <= 1'b0;
	end
end
brake_filter u_filt0
(
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.raw_in(brake_input_zero_in),
	.sel_in(c4_reg[5:4]),
	.level_out(f0)
);
brake_filter u_filt1
(
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.raw_in(brake_input_one_in),
	.sel_in(c4_reg[7:6]),
	.level_out(f1)
);
// ****************
// Control registers
// ****************
always @*
begin
	c1_next = c1_reg;
	if (wen && a_reg == `OFS_CTRL_ONE)
	begin
		c1_next = {wd[7:6], wd[5] & c1_reg[5], wd[4],
			wd[3:2] & c1_reg[3:2], wd[1:0]};
	end
	if (b0_fall)
	begin
		c1_next[`C1_FLAG0] = 1'b1;
		c1_next[`C1_RUN] = 1'b0;
	end
	if (b1_fall)
		c1_next[`C1_FLAG1] = 1'b1;
	if (ievt)
		c1_next[`C1_IFLAG] = 1'b1;
end
wire ta_ok = ta_open_reg;
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		c1_reg <= `RST_BYTE;
		c3_reg <= `RST_BYTE;
		c4_reg <= `RST_BYTE;
		blev_reg <= `RST_BYTE;
		pol_reg <= `RST_BYTE;
		dten_reg <= `RST_BYTE;
		dtc_reg <= `RST_BYTE;
		psc_reg <= `RST_BYTE;
		cfg_done_reg <= 1'b0;
		ta_cnt_reg <= 5'd0;
		ta_armed_reg <= 1'b0;
		ta_open_reg <= 1'b0;
		irq_reg <= 1'b0;
	end
	else
	begin
		c1_reg <= c1_next;
		irq_reg <= c1_next[`C1_IFLAG] & ext_irq_enable_one_in;
		cfg_done_reg <= 1'b1;
		if (!cfg_done_reg)
			c3_reg[7:6] <= {hz_config_in[0], hz_config_in[1]};
		else if (wen && a_reg == `OFS_CTRL_THREE)
			c3_reg <= {wd[7:4], 2'b00, wd[1:0]};
		if (wen && a_reg == `OFS_CTRL_FOUR)
			c4_reg <= {wd[7:3], 1'b0, wd[1:0]};
		if (wen && a_reg == `OFS_BRAKE_LEVEL)
			blev_reg <= {2'b00, wd[5:0]};
		if (wen && a_reg == `OFS_POLARITY)
			pol_reg <= {2'b00, wd[5:0]};
		if (wen && a_reg == `OFS_PRESCALE)
			psc_reg <= wd;
		if (wen && a_reg == `OFS_DT_ENABLE && ta_ok)
			dten_reg <= {5'b00000, wd[2:0]};
		if (wen && a_reg == `OFS_DT_COUNT && ta_ok)
			dtc_reg <= wd;
		if (wen && a_reg == `OFS_TA_KEY && wd == `TA_KEY_FIRST)
		begin
			ta_armed_reg <= 1'b1;
			ta_open_reg <= 1'b0;
			ta_cnt_reg <= `TA_WIN_CYC;
		end
		else if (wen && a_reg == `OFS_TA_KEY && wd == `TA_KEY_SECOND
			&& ta_armed_reg)
		begin
			ta_armed_reg <= 1'b0;
			ta_open_reg <= 1'b1;
			ta_cnt_reg <= `TA_WIN_CYC;
		end
		else if (wen && a_reg == `OFS_TA_KEY)
			ta_armed_reg <= 1'b0;
		else if (ta_cnt_reg != 5'd0)
			ta_cnt_reg <= ta_cnt_reg - 5'd1;
		else
		begin
			ta_armed_reg <= 1'b0;
			ta_open_reg <= 1'b0;
		end
	end
end
// ****************
// Pairing and pins
// ****************
wire [1:0] pair_mode_select = c1_reg[1:0];
wire comp = pair_mode_select[0];
wire group_follow = (pair_mode_select == 2'b11) & c3_reg[`C3_GROUP];
wire [2:0] pe = {group_follow ? gen_reg[0] : gen_reg[2],
	group_follow ? gen_reg[0] : gen_reg[1], gen_reg[0]};
genvar g;
generate
	for (g = 0; g < 3; g = g + 1)
	begin : pair
		deadtime_pair u_dt
		(
			.clk_in(clk_in),
			.reset_n_in(reset_n_in),
			.level_in(pe[g]),
			.en_in(dten_reg[g] & comp),
			.count_in(dtc_reg),
			.even_out(dt_even[g]),
			.odd_out(dt_odd[g])
		);
	end
endgenerate
always @*
begin
	for (n = 0; n < 3; n = n + 1)
	begin
		if (comp)
			raw[2 * n +: 2] = {dt_odd[n], dt_even[n]};
		else if (pair_mode_select == 2'b10)
			raw[2 * n +: 2] = {pe[n], pe[n]};
		else
			raw[2 * n +: 2] = {1'b0, pe[n]};
	end
end
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		pwm_reg <= 8'h00;
		oe_n_reg <= 8'hFF;
	end
	else
	begin
		pwm_reg[5:0] <= (forced ? blev_reg[5:0] : raw) ^ pol_reg[5:0];
		pwm_reg[6] <= c3_reg[`C3_CH6_SEL] ? gen_reg[1] : gen_reg[3];
		pwm_reg[7] <= gen_reg[2];
		for (k = 0; k < 8; k = k + 1)
			oe_n_reg[k] <= in_circuit_programming | port_mode_regs_n_in[k] |
				(k[0] ? c3_reg[`C3_ODD_OUTPUTS_HIGH_Z] : c3_reg[`C3_EVEN_OUTPUTS_HIGH_Z]);
	end
end
assign pwm_out = pwm_reg;
assign pwm_oe_n_out = oe_n_reg;
assign irq_request_out = irq_reg;
endmodule // motor_pwm_timebase_brake

/* verilog/motor_pwm_regs.vh */
`ifndef MOTOR_PWM_REGS_VH
`define MOTOR_PWM_REGS_VH
// ****************
// Register offsets
// ****************
`define OFS_BUF_LAST 8'h24
`define OFS_CTRL_ONE 8'h28
`define OFS_CTRL_THREE 8'h2C
`define OFS_CTRL_FOUR 8'h30
`define OFS_BRAKE_LEVEL 8'h34
`define OFS_POLARITY 8'h38
`define OFS_DT_ENABLE 8'h3C
`define OFS_DT_COUNT 8'h40
`define OFS_TA_KEY 8'h44
`define OFS_PRESCALE 8'h48
`define OFS_CNT_LO 8'h4C
`define OFS_CNT_HI 8'h50
// ****************
// Field positions
// ****************
`define C1_RUN 7
`define C1_LOAD 6
`define C1_IFLAG 5
`define C1_FLAG1 3
`define C1_FLAG0 2
`define C3_EVEN_OUTPUTS_HIGH_Z 7
`define C3_ODD_OUTPUTS_HIGH_Z 6
`define C3_GROUP 5
`define C3_CENTER 4
`define C3_CH6_SEL 1
`define C3_INT_TYPE 0
`define C4_AUTO1 3
// ****************
// Reset values and full-duty value
// ****************
`define RST_BYTE 8'h00
`define RST_VAL12 12'h000
`define DUTY_ALL_ONES 12'hFFF
// ****************
// Keys and timing
// ****************
`define TA_KEY_FIRST 8'hAA
`define TA_KEY_SECOND 8'h55
`define TA_WIN_CYC 5'd12
`define BF_LEN0 5'd1
`define BF_LEN1 5'd4
`define BF_LEN2 5'd8
`define BF_LEN3 5'd16
`endif

/* verilog/brake_filter.v */
`timescale 1ns/10ps
`include "motor_pwm_regs.vh"
module brake_filter
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Pin and setting
	input wire raw_in,
	input wire [1:0] sel_in,
	// Filtered level
	output reg level_out
);
reg [4:0] cnt_reg;
reg [4:0] len;
always @*
begin
	case (sel_in)
	2'd0: len = `BF_LEN0;
	2'd1: len = `BF_LEN1;
	2'd2: len = `BF_LEN2;
	default: len = `BF_LEN3;
	endcase
end
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		cnt_reg <= 5'd0;
		level_out <= 1'b1;
	end
	else if (raw_in == level_out)
		cnt_reg <= 5'd0;
	else if (cnt_reg == len - 5'd1)
	begin
		level_out <= raw_in;
		cnt_reg <= 5'd0;
	end
	else
		cnt_reg <= cnt_reg + 5'd1;
end
endmodule // brake_filter

/* verilog/deadtime_pair.v */
`timescale 1ns/10ps
module deadtime_pair
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Pair control
	input wire level_in,
	input wire en_in,
	input wire [7:0] count_in,
	// Delayed pair
	output reg even_out,
	output reg odd_out
);
reg lvl_reg;
reg busy_reg;
reg [7:0] cnt_reg;
always @(posedge clk_in or negedge reset_n_in)
begin
	if (!reset_n_in)
	begin
		lvl_reg <= 1'b0;
		busy_reg <= 1'b0;
		cnt_reg <= 8'h00;
		even_out <= 1'b0;
		odd_out <= 1'b0;
	end
	else
	begin
		lvl_reg <= level_in;
		if (!en_in)
		begin
			busy_reg <= 1'b0;
			even_out <= level_in;
			odd_out <= ~level_in;
		end
		else if (level_in != lvl_reg)
		begin
			busy_reg <= 1'b1;
			cnt_reg <= count_in;
			even_out <= 1'b0;
			odd_out <= 1'b0;
		end
		else if (busy_reg && cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
		else
		begin
			busy_reg <= 1'b0;
			even_out <= lvl_reg;
			odd_out <= ~lvl_reg;
		end
	end
end
endmodule // deadtime_pair

/* sim/motor_pwm_asserts.sv */
`timescale 1ns/10ps
module motor_pwm_asserts
(
	// Clock and reset
	input wire clk_in,
	input wire reset_n_in,
	// Bus
	input wire hsel_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire hready_in,
	input wire [31:0] hrdata_out,
	input wire hreadyout_out,
	input wire hresp_out,
	// Pins
	input wire in_circuit_programming_in,
	input wire [7:0] port_mode_regs_n_in,
	input wire ext_irq_enable_one_in,
	input wire [7:0] pwm_oe_n_out,
	input wire irq_request_out
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	wire take = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'b010);
	wire rd_take = take & !hwrite_in;
	wire wr_take = take & hwrite_in;
	a_resp_okay: assert property (hresp_out == 1'b0)
		else $error("response not okay");
	a_read_wait: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
		else $error("read wait wrong");
	a_write_nowait: assert property (wr_take |=> hreadyout_out)
		else $error("write stalled");
	a_wait_single: assert property (!hreadyout_out |=> hreadyout_out)
		else $error("wait too long");
	a_rdata_upper: assert property (hrdata_out[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_rdata_hold: assert property ($changed(hrdata_out) |-> !$past(hreadyout_out))
		else $error("read data moved");
	a_icp_float: assert property (in_circuit_programming_in |=> pwm_oe_n_out == 8'hFF)
		else $error("pins driven in programming");
	a_port_float: assert property (1'b1 |=> (pwm_oe_n_out & $past(port_mode_regs_n_in)) == $past(port_mode_regs_n_in))
		else $error("port mode ignored");
	a_irq_enable: assert property (irq_request_out |-> $past(ext_irq_enable_one_in))
		else $error("request while disabled");
	cover property (rd_take);
	cover property (in_circuit_programming_in);
	cover property (irq_request_out);
endmodule // motor_pwm_asserts
bind motor_pwm_timebase_brake motor_pwm_asserts i_motor_pwm_asserts
(
	.clk_in, .reset_n_in, .hsel_in, .htrans_in, .hwrite_in, .hsize_in,
	.hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
	.in_circuit_programming_in, .port_mode_regs_n_in,
	.ext_irq_enable_one_in, .pwm_oe_n_out, .irq_request_out
);

/* sim/brake_source.sv */
`timescale 1ns/10ps
module brake_source
(
	// Clock
	input wire logic clk_in,
	// Command
	input wire logic [1:0] trip_in,
	// Brake pins
	output logic brake_input_zero_out,
	output logic brake_input_one_out
);
	// ****************
	// Pins
	// ****************
	logic [1:0] lvl = 2'b11;
	// pulled up, low only on command
	always @(posedge clk_in)
		lvl <= ~trip_in;
	assign brake_input_zero_out = lvl[0];
	assign brake_input_one_out = lvl[1];
endmodule // brake_source

/* sim/tb_motor_pwm_timebase_brake.sv */
`timescale 1ns/10ps
module tb_motor_pwm_timebase_brake;
	// ****************
	// Signals
	// ****************
	logic clk_in, reset_n_in, hsel_in, hwrite_in, g;
	logic in_circuit_programming_in, ext_irq_enable_one_in;
	logic [31:0] haddr_in, hwdata_in;
	logic [1:0] htrans_in, hz_config_in, trip;
	logic [2:0] hsize_in;
	logic [7:0] port_mode_regs_n_in, q;
	wire hready_in, hreadyout_out, hresp_out, irq_request_out;
	wire brake_input_zero_in, brake_input_one_in;
	wire [31:0] hrdata_out;
	wire [7:0] pwm_out, pwm_oe_n_out;
	int n_fail, n_tests, c;
	int dv[4] = '{4, 32, 0, 4095};
	int ev[4] = '{40, 100, 0, 100};
	assign hready_in = hreadyout_out;
	motor_pwm_timebase_brake i_motor_pwm_timebase_brake
	(
		.clk_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
		.hsize_in, .hready_in, .hwdata_in, .hrdata_out, .hreadyout_out,
		.hresp_out, .brake_input_zero_in, .brake_input_one_in,
		.in_circuit_programming_in, .port_mode_regs_n_in, .hz_config_in,
		.ext_irq_enable_one_in, .pwm_out, .pwm_oe_n_out, .irq_request_out
	);
	brake_source i_brake_source
	(
		.clk_in, .trip_in(trip),
		.brake_input_zero_out(brake_input_zero_in),
		.brake_input_one_out(brake_input_one_in)
	);
	initial
	begin
		clk_in = 0;
		forever #2 clk_in = ~clk_in;
	end
	// ****************
	// Tasks
	// ****************
	task chk(input [31:0] gv, input [31:0] e);
		n_tests++;
		if (gv !== e)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, gv, e);
		end
	endtask
	task xf(input w, input [7:0] a, input [7:0] d);
		@(posedge clk_in);
		hwrite_in <= w;
		haddr_in <= {24'h00_0000, a};
		htrans_in <= 2'b10;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'b00;
		hwdata_in <= {24'h00_0000, d};
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		q = hrdata_out[7:0];
	endtask
	task w12(input [7:0] a, input [11:0] v);
		xf(1, a, v[7:0]);
		xf(1, a + 8'h04, {4'h0, v[11:8]});
	endtask
	task cnt(input int len, output int n);
		n = 0;
		repeat (len)
		begin
			@(negedge clk_in);
			n += pwm_out[0];
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task results;
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		results;
	end
	// ****************
	// Tests
	// ****************
	initial
	begin
		reset_n_in = 0;
		hsel_in = 1;
		hsize_in = 3'b010;
		{haddr_in, hwdata_in, htrans_in, hwrite_in, trip} = 0;
		{in_circuit_programming_in, port_mode_regs_n_in, hz_config_in} = 0;
		ext_irq_enable_one_in = 1;
		tick(6);
		reset_n_in <= 1;
		tick(3);
		chk(pwm_out, 0);
		chk(pwm_oe_n_out, 0);
		w12(8'h00, 12'h934);
		xf(0, 8'h00, 0);
		chk(q, 8'h34);
		xf(0, 8'h04, 0);
		chk(q, 8'h09);
		xf(0, 8'h80, 0);
		chk(q, 0);
		xf(1, 8'h40, 8'h05);
		xf(0, 8'h40, 0);
		chk(q, 0);
		xf(1, 8'h44, 8'hAA);
		xf(1, 8'h44, 8'h55);
		xf(1, 8'h40, 8'h05);
		xf(0, 8'h40, 0);
		chk(q, 8'h05);
		w12(8'h00, 12'h009);
		w12(8'h10, 12'hFFF);
		w12(8'h18, 0);
		w12(8'h20, 0);
		xf(1, 8'h28, 8'hC0);
		for (int i = 0; i < 4; i++)
		begin
			w12(8'h08, dv[i][11:0]);
			tick(30);
			cnt(100, c);
			chk(c, ev[i]);
		end
		w12(8'h08, 12'h004);
		tick(30);
		chk(irq_request_out, 1);
		ext_irq_enable_one_in <= 0;
		tick(3);
		chk(irq_request_out, 0);
		ext_irq_enable_one_in <= 1;
		for (int m = 0; m < 4; m++)
		begin
			xf(1, 8'h2C, m == 3 ? 8'h22 : 8'h02);
			xf(1, 8'h28, 8'hC0 | m[7:0]);
			tick(5);
			repeat (20)
			begin
				@(negedge clk_in);
				g = pwm_out[0];
				case (m)
					0: chk(pwm_out, {7'b0100010, g});
					1: chk(pwm_out[5:0], {4'b1001, ~g, g});
					2: chk(pwm_out[5:0], {4'b0011, g, g});
					default: chk(pwm_out[5:0], {3{~g, g}});
				endcase
			end
		end
		xf(1, 8'h2C, 8'h00);
		xf(1, 8'h44, 8'hAA);
		xf(1, 8'h44, 8'h55);
		xf(1, 8'h40, 8'h01);
		xf(1, 8'h3C, 8'h01);
		xf(1, 8'h28, 8'hC1);
		tick(30);
		c = 0;
		repeat (100)
		begin
			@(negedge clk_in);
			c += (pwm_out[1:0] == 2'b00) + 1000 * (pwm_out[1:0] == 2'b11);
		end
		chk(c, 40);
		xf(1, 8'h2C, 8'h10);
		xf(1, 8'h28, 8'hC0);
		tick(40);
		cnt(90, c);
		chk(c, 35);
		xf(1, 8'h2C, 0);
		xf(1, 8'h28, 8'hC0);
		xf(1, 8'h34, 8'h15);
		xf(1, 8'h38, 8'h01);
		trip <= 2'b01;
		tick(10);
		trip <= 0;
		xf(0, 8'h28, 0);
		chk(q & 8'h8C, 8'h80);
		xf(1, 8'h30, 8'h03);
		trip <= 2'b01;
		tick(10);
		chk(pwm_out[5:0], 6'h14);
		xf(0, 8'h28, 0);
		chk(q & 8'h8C, 8'h04);
		trip <= 0;
		xf(1, 8'h28, 8'h40);
		tick(30);
		chk(pwm_out[5:0], 6'h14);
		xf(1, 8'h28, 8'hC0);
		tick(30);
		chk(pwm_out[5:1], 5'b00010);
		xf(1, 8'h30, 8'hCB);
		trip <= 2'b10;
		tick(8);
		chk(pwm_out[5:1], 5'b00010);
		tick(17);
		chk(pwm_out[5:1], 5'b01010);
		xf(0, 8'h28, 0);
		chk(q & 8'h88, 8'h88);
		trip <= 0;
		tick(40);
		chk(pwm_out[5:1], 5'b00010);
		port_mode_regs_n_in <= 8'h0F;
		tick(3);
		chk(pwm_oe_n_out, 8'h0F);
		in_circuit_programming_in <= 1;
		tick(3);
		chk(pwm_oe_n_out, 8'hFF);
		in_circuit_programming_in <= 0;
		port_mode_regs_n_in <= 0;
		hz_config_in <= 2'b01;
		reset_n_in <= 0;
		tick(6);
		reset_n_in <= 1;
		tick(4);
		chk(pwm_oe_n_out, 8'h55);
		results;
	end
endmodule // tb_motor_pwm_timebase_brake
